// ### design/sme_regs.svh
// Constants shared by both ends of the two-wire EEPROM link.
// Included by each end and by the bench; definitions only.
`ifndef SME_REGS_SVH
`define SME_REGS_SVH
`define SME_TYPE_MAIN  4'ha
`define SME_TYPE_EXTRA 4'hb
`define SME_SEL_SEC    2'h0
`define SME_SEL_ID     2'h1
`define SME_SEL_LOCK   2'h2
`define SME_PAGE_BYTES 64
`define SME_MAIN_BYTES 32768
`define SME_T_WR_NS    5000000
`define SME_CLK_NS     8
`define SME_SCL_NS     2500
`define SME_LAST_BIT   3'h7
`define SME_LAST_Q     2'h3
`endif

// ### design/sme_pkg.sv
// Types shared by the EEPROM device end and the bus host end.
// Assumes sme_regs.svh is on the include path.
package sme_pkg;
	typedef enum logic [2:0] {
		D_IDLE = 3'h0, D_DEV = 3'h1, D_AHI = 3'h2, D_ALO = 3'h3,
		D_WDATA = 3'h4, D_ACK = 3'h5, D_RDATA = 3'h6, D_MACK = 3'h7
	} sme_dev_st_t;
	typedef enum logic [2:0] {
		R_MAIN = 3'h0, R_SEC = 3'h1, R_ID = 3'h2, R_LOCK = 3'h3, R_NONE = 3'h4
	} sme_region_t;
	typedef enum logic [2:0] {
		H_IDLE = 3'h0, H_START = 3'h1, H_TX = 3'h2, H_RACK = 3'h3,
		H_RX = 3'h4, H_TACK = 3'h5, H_STOP = 3'h6
	} sme_host_st_t;
endpackage

// ### design/sme_if.sv
// Two-wire link between the bus host and the EEPROM device.
// Resolves the open-drain data line with a pull-up; host owns the clock.
`timescale 1ns/1ps
interface sme_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;
	// Wired-AND: any enabled low driver pulls the line down
	assign sda = !((host_sda_oe & !host_sda_o) | (dev_sda_oe & !dev_sda_o));
	modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
	modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// ### design/sme_device.sv
// EEPROM device end: main array, lockable security sector, factory id.
// Assumes scl and sda are synchronous to clock and slower than it.
`timescale 1ns/1ps
`include "sme_regs.svh"
module sme_device
	import sme_pkg::*;
#(
	parameter int         WR_CYCLES  = `SME_T_WR_NS / `SME_CLK_NS,
	parameter logic [127:0] FACTORY_ID = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0 // Arbitrary value
)(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rst,
	// Straps
	input  wire logic [2:0] bus_select_inputs,
	input  wire logic       write_guard,
	// Status
	output logic            write_busy,
	output logic            sec_locked,
	// Link
	sme_if.device           link
);
	localparam int TW = $clog2(WR_CYCLES + 1);

	sme_dev_st_t st_reg, st_next, nxt_reg, nxt_next;
	sme_region_t rg_reg, rg_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic [7:0]  sh_reg, sh_next, ahi_reg, ahi_next;
	logic [3:0]  typ_reg, typ_next;
	logic [14:0] addr_reg, addr_next;
	logic        scl_d_reg, sda_d_reg;
	logic        oe_reg, oe_next, ackon_reg, ackon_next, ackok_reg, ackok_next;
	logic        busy_reg, busy_next, lock_reg, lock_next, lpend_reg, lpend_next;
	logic [TW-1:0] tmr_reg, tmr_next;
	logic [6:0]  cidx_reg, cidx_next;
	logic [63:0] pmask_reg, pmask_next;
	logic        pb_we, mm_we, ms_we;
	logic [5:0]  pb_idx;
	logic        rise, fall, start_c, stop_c, ok;
	logic [7:0]  rx, rd_byte;

	// Nonvolatile arrays and page latch; no reset, contents persist
	logic [7:0] mem_main [0:`SME_MAIN_BYTES-1];
	logic [7:0] mem_sec  [0:`SME_PAGE_BYTES-1];
	logic [7:0] pbuf     [0:`SME_PAGE_BYTES-1];

	// Region decode from type code and word address
	function automatic sme_region_t region_of(input logic [3:0] t, input logic [14:0] a);
		sme_region_t r;
		r = R_NONE;
		if (t == `SME_TYPE_MAIN)
			r = R_MAIN;
		else if (a[10:9] == `SME_SEL_SEC)
			r = R_SEC;
		else if (a[10:9] == `SME_SEL_ID)
			r = R_ID;
		else if (a[10:9] == `SME_SEL_LOCK)
			r = R_LOCK;
		return r;
	endfunction

	// Sequential read pointer wraps inside its own region
	function automatic logic [14:0] addr_inc(input sme_region_t r, input logic [14:0] a);
		logic [14:0] n;
		n = a;
		case (r)
			R_MAIN:  n = a + 15'h0001;
			R_SEC:   n[5:0] = a[5:0] + 6'h01;
			R_ID:    n[3:0] = a[3:0] + 4'h1;
			default: n = a;
		endcase
		return n;
	endfunction

	// Bus events seen on the sampled lines
	always_comb
	begin
		rise    = link.scl & !scl_d_reg;
		fall    = !link.scl & scl_d_reg;
		start_c = link.scl & scl_d_reg & sda_d_reg & !link.sda;
		stop_c  = link.scl & scl_d_reg & !sda_d_reg & link.sda;
		rx      = {sh_reg[6:0], link.sda};
		case (rg_reg)
			R_MAIN:  rd_byte = mem_main[addr_reg];
			R_SEC:   rd_byte = mem_sec[addr_reg[5:0]];
			R_ID:    rd_byte = FACTORY_ID[{addr_reg[3:0], 3'h0} +: 8];
			default: rd_byte = 8'hff;
		endcase
	end

	// Protocol engine and self-timed write
	always_comb
	begin
		st_next = st_reg; nxt_next = nxt_reg; rg_next = rg_reg;
		cnt_next = cnt_reg; sh_next = sh_reg; ahi_next = ahi_reg;
		typ_next = typ_reg; addr_next = addr_reg; oe_next = oe_reg;
		ackon_next = ackon_reg; ackok_next = ackok_reg;
		busy_next = busy_reg; lock_next = lock_reg; lpend_next = lpend_reg;
		tmr_next = tmr_reg; cidx_next = cidx_reg; pmask_next = pmask_reg;
		pb_we = 1'b0; mm_we = 1'b0; ms_we = 1'b0; pb_idx = addr_reg[5:0];
		// Open pins are pulled down outside, so they arrive as zero
		ok = (rx[3:1] == bus_select_inputs) && !busy_reg
			&& (rx[7:4] == `SME_TYPE_MAIN || rx[7:4] == `SME_TYPE_EXTRA);
		if (start_c)
		begin
			st_next = D_DEV;
			cnt_next = 3'h0;
			oe_next = 1'b0;
			ackon_next = 1'b0;
		end
		else if (stop_c)
		begin
			st_next = D_IDLE;
			oe_next = 1'b0;
			// Programming starts only at stop after accepted data bytes
			if (st_reg == D_WDATA && |pmask_reg && !write_guard
				&& (rg_reg == R_MAIN || ((rg_reg == R_SEC || rg_reg == R_LOCK) && !lock_reg)))
			begin
				busy_next = 1'b1;
				tmr_next = TW'(WR_CYCLES - 1);
				cidx_next = 7'h00;
				lpend_next = (rg_reg == R_LOCK);
			end
			else if (!busy_reg)
				pmask_next = 64'h0; // A refused poll must not empty the latch mid-commit
		end
		else
		begin
			case (st_reg)
				D_DEV, D_AHI, D_ALO, D_WDATA:
				begin
					if (rise)
					begin
						sh_next = rx;
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == `SME_LAST_BIT)
						begin
							st_next = D_ACK;
							ackon_next = 1'b0;
							ackok_next = 1'b1;
							case (st_reg)
								D_DEV:
								begin
									ackok_next = ok;
									// A refused address leaves the pending write's region alone
									if (ok)
									begin
										typ_next = rx[7:4];
										rg_next = region_of(rx[7:4], addr_reg);
									end
									nxt_next = !ok ? D_IDLE : (rx[0] ? D_RDATA : D_AHI);
								end
								D_AHI:
								begin
									ahi_next = rx;
									nxt_next = D_ALO;
								end
								D_ALO:
								begin
									addr_next = {ahi_reg[6:0], rx};
									rg_next = region_of(typ_reg, {ahi_reg[6:0], rx});
									pmask_next = 64'h0;
									nxt_next = D_WDATA;
								end
								default:
								begin
									// Roll over inside the page, never into the next
									pb_we = 1'b1;
									pmask_next[addr_reg[5:0]] = 1'b1;
									addr_next[5:0] = addr_reg[5:0] + 6'h01;
									nxt_next = D_WDATA;
								end
							endcase
						end
					end
				end
				D_ACK:
				begin
					if (fall && !ackon_reg)
					begin
						ackon_next = 1'b1;
						oe_next = ackok_reg;
					end
					else if (fall)
					begin
						ackon_next = 1'b0;
						cnt_next = 3'h0;
						st_next = nxt_reg;
						oe_next = 1'b0;
						if (nxt_reg == D_RDATA)
						begin
							sh_next = rd_byte;
							oe_next = !rd_byte[7];
							addr_next = addr_inc(rg_reg, addr_reg);
						end
					end
				end
				D_RDATA:
				begin
					if (fall)
						oe_next = !sh_reg[7];
					if (rise)
					begin
						sh_next = {sh_reg[6:0], 1'b0};
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == `SME_LAST_BIT)
							st_next = D_MACK;
					end
				end
				D_MACK:
				begin
					if (fall)
						oe_next = 1'b0;
					if (rise)
					begin
						// Host low means it wants another byte
						st_next = link.sda ? D_IDLE : D_RDATA;
						cnt_next = 3'h0;
						if (!link.sda)
						begin
							sh_next = rd_byte;
							addr_next = addr_inc(rg_reg, addr_reg);
						end
					end
				end
				default:
					st_next = st_reg;
			endcase
		end
		// Commit one latched byte per cycle, then run out the timer
		if (busy_reg)
		begin
			tmr_next = tmr_reg - TW'(1);
			if (!cidx_reg[6])
			begin
				cidx_next = cidx_reg + 7'h01;
				mm_we = pmask_reg[cidx_reg[5:0]] && rg_reg == R_MAIN;
				ms_we = pmask_reg[cidx_reg[5:0]] && rg_reg == R_SEC;
			end
			if (tmr_reg == '0)
			begin
				busy_next = 1'b0;
				pmask_next = 64'h0;
				lpend_next = 1'b0;
				lock_next = lock_reg | lpend_reg;
			end
		end
	end

	// Array write ports
	always_ff @(posedge clock)
	begin
		if (pb_we)
			pbuf[pb_idx] <= rx;
		if (mm_we)
			mem_main[{addr_reg[14:6], cidx_reg[5:0]}] <= pbuf[cidx_reg[5:0]];
		if (ms_we)
			mem_sec[cidx_reg[5:0]] <= pbuf[cidx_reg[5:0]];
	end

	// State registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_reg <= D_IDLE; nxt_reg <= D_IDLE; rg_reg <= R_MAIN;
			cnt_reg <= 3'h0; sh_reg <= 8'h00; ahi_reg <= 8'h00;
			typ_reg <= 4'h0; addr_reg <= 15'h0000;
			scl_d_reg <= 1'b1; sda_d_reg <= 1'b1;
			oe_reg <= 1'b0; ackon_reg <= 1'b0; ackok_reg <= 1'b0;
			busy_reg <= 1'b0; lock_reg <= 1'b0; lpend_reg <= 1'b0;
			tmr_reg <= '0; cidx_reg <= 7'h00; pmask_reg <= 64'h0;
		end
		else
		begin
			st_reg <= st_next; nxt_reg <= nxt_next; rg_reg <= rg_next;
			cnt_reg <= cnt_next; sh_reg <= sh_next; ahi_reg <= ahi_next;
			typ_reg <= typ_next; addr_reg <= addr_next;
			scl_d_reg <= link.scl; sda_d_reg <= link.sda;
			oe_reg <= oe_next; ackon_reg <= ackon_next; ackok_reg <= ackok_next;
			busy_reg <= busy_next; lock_reg <= lock_next; lpend_reg <= lpend_next;
			tmr_reg <= tmr_next; cidx_reg <= cidx_next; pmask_reg <= pmask_next;
		end
	end

	// Pin never driven high: open-drain only
	assign link.dev_sda_o  = 1'b0;
	assign link.dev_sda_oe = oe_reg;
	assign write_busy      = busy_reg;
	assign sec_locked      = lock_reg;
endmodule

// ### design/sme_host.sv
// Bus host end: makes the serial clock and runs whole transfers.
// Assumes the caller holds request fields stable while busy.
`timescale 1ns/1ps
`include "sme_regs.svh"
module sme_host
	import sme_pkg::*;
#(
	// Quarter of a serial clock period, rounded up so the rate stays in limit
	parameter int QUARTER = (`SME_SCL_NS + 4 * `SME_CLK_NS - 1) / (4 * `SME_CLK_NS)
)(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Request
	input  wire logic        req,
	input  wire logic        req_read,
	input  wire logic [3:0]  req_type,
	input  wire logic [2:0]  req_sel,
	input  wire logic [14:0] req_addr,
	input  wire logic [6:0]  req_len,
	input  wire logic [7:0]  wdata,
	// Answer
	output logic             host_busy,
	output logic             wdata_take,
	output logic [7:0]       rdata,
	output logic             rdata_valid,
	output logic             done,
	output logic             nack_seen,
	// Link
	sme_if.host              link
);
	localparam int QW = $clog2(QUARTER + 1);

	sme_host_st_t st_reg, st_next;
	logic [QW-1:0] tick_reg, tick_next;
	logic [1:0]  q_reg, q_next, stg_reg, stg_next;
	logic [2:0]  cnt_reg, cnt_next;
	logic [7:0]  sh_reg, sh_next, rd_reg, rd_next;
	logic [6:0]  left_reg, left_next;
	logic        scl_reg, scl_next, oe_reg, oe_next, rdp_reg, rdp_next;
	logic        busy_reg, busy_next, take_reg, take_next, rv_reg, rv_next;
	logic        done_reg, done_next, nack_reg, nack_next, qt;

	// Quarter-period sequencer; actions fire as each quarter ends
	always_comb
	begin
		st_next = st_reg; q_next = q_reg; stg_next = stg_reg; cnt_next = cnt_reg;
		sh_next = sh_reg; rd_next = rd_reg; left_next = left_reg;
		scl_next = scl_reg; oe_next = oe_reg; rdp_next = rdp_reg; busy_next = busy_reg;
		take_next = 1'b0; rv_next = 1'b0; done_next = 1'b0; nack_next = nack_reg;
		qt = (tick_reg == QW'(QUARTER - 1));
		tick_next = qt ? '0 : tick_reg + QW'(1);
		if (st_reg == H_IDLE)
		begin
			tick_next = '0;
			q_next = 2'h0;
			if (req)
			begin
				st_next = H_START; stg_next = 2'h0; rdp_next = 1'b0;
				left_next = req_len; busy_next = 1'b1; nack_next = 1'b0;
			end
		end
		else if (qt)
		begin
			q_next = q_reg + 2'h1;
			// Clock rises after quarter 1 and falls after quarter 3
			if (q_reg == 2'h0)
				scl_next = scl_reg;
			if (q_reg == 2'h1)
				scl_next = 1'b1;
			if (q_reg == `SME_LAST_Q)
				scl_next = 1'b0;
			case (st_reg)
				H_START:
				begin
					// Data falls while clock is high
					if (q_reg == 2'h0)
						oe_next = 1'b0;
					if (q_reg == 2'h2)
						oe_next = 1'b1;
					if (q_reg == `SME_LAST_Q)
					begin
						st_next = H_TX; cnt_next = 3'h0;
						sh_next = {req_type, req_sel, rdp_reg};
					end
				end
				H_TX:
				begin
					// Data set while clock is low, held over the rise
					if (q_reg == 2'h0)
						oe_next = !sh_reg[7];
					if (q_reg == `SME_LAST_Q)
					begin
						sh_next = {sh_reg[6:0], 1'b0};
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == `SME_LAST_BIT)
							st_next = H_RACK;
					end
				end
				H_RACK:
				begin
					if (q_reg == 2'h0)
						oe_next = 1'b0;
					if (q_reg == 2'h2)
						nack_next = link.sda;
					if (q_reg == `SME_LAST_Q)
					begin
						cnt_next = 3'h0;
						st_next = H_TX;
						// A busy device refuses its address; caller retries
						if (nack_reg)
							st_next = H_STOP;
						else if (stg_reg == 2'h0 && rdp_reg)
							st_next = H_RX;
						else if (stg_reg == 2'h0)
						begin
							stg_next = 2'h1;
							sh_next = {1'b0, req_addr[14:8]};
						end
						else if (stg_reg == 2'h1)
						begin
							stg_next = 2'h2;
							sh_next = req_addr[7:0];
						end
						else if (stg_reg == 2'h2 && req_read)
						begin
							st_next = H_START;
							rdp_next = 1'b1;
							stg_next = 2'h0;
						end
						else if (stg_reg == 2'h2 || left_reg != 7'h01)
						begin
							if (stg_reg == 2'h3)
								left_next = left_reg - 7'h01;
							stg_next = 2'h3;
							sh_next = wdata;
							take_next = 1'b1;
						end
						else
							st_next = H_STOP;
					end
				end
				H_RX:
				begin
					if (q_reg == 2'h0)
						oe_next = 1'b0;
					if (q_reg == 2'h2)
						sh_next = {sh_reg[6:0], link.sda};
					if (q_reg == `SME_LAST_Q)
					begin
						cnt_next = cnt_reg + 3'h1;
						if (cnt_reg == `SME_LAST_BIT)
						begin
							st_next = H_TACK; rd_next = sh_reg; rv_next = 1'b1;
						end
					end
				end
				H_TACK:
				begin
					// Acknowledge all but the last byte
					if (q_reg == 2'h0)
						oe_next = (left_reg != 7'h01);
					if (q_reg == `SME_LAST_Q)
					begin
						left_next = left_reg - 7'h01;
						cnt_next = 3'h0;
						st_next = (left_reg == 7'h01) ? H_STOP : H_RX;
					end
				end
				H_STOP:
				begin
					// Data rises while clock is high
					if (q_reg == 2'h0)
						oe_next = 1'b1;
					if (q_reg == 2'h2)
						oe_next = 1'b0;
					if (q_reg == `SME_LAST_Q)
					begin
						st_next = H_IDLE; scl_next = 1'b1;
						busy_next = 1'b0; done_next = 1'b1;
					end
				end
				default:
					st_next = H_IDLE;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_reg <= H_IDLE; tick_reg <= '0; q_reg <= 2'h0; stg_reg <= 2'h0;
			cnt_reg <= 3'h0; sh_reg <= 8'h00; rd_reg <= 8'h00; left_reg <= 7'h00;
			scl_reg <= 1'b1; oe_reg <= 1'b0; rdp_reg <= 1'b0; busy_reg <= 1'b0;
			take_reg <= 1'b0; rv_reg <= 1'b0; done_reg <= 1'b0; nack_reg <= 1'b0;
		end
		else
		begin
			st_reg <= st_next; tick_reg <= tick_next; q_reg <= q_next; stg_reg <= stg_next;
			cnt_reg <= cnt_next; sh_reg <= sh_next; rd_reg <= rd_next; left_reg <= left_next;
			scl_reg <= scl_next; oe_reg <= oe_next; rdp_reg <= rdp_next; busy_reg <= busy_next;
			take_reg <= take_next; rv_reg <= rv_next; done_reg <= done_next; nack_reg <= nack_next;
		end
	end

	assign link.scl         = scl_reg;
	assign link.host_sda_o  = 1'b0;
	assign link.host_sda_oe = oe_reg;
	assign host_busy        = busy_reg;
	assign wdata_take       = take_reg;
	assign rdata            = rd_reg;
	assign rdata_valid      = rv_reg;
	assign done             = done_reg;
	assign nack_seen        = nack_reg;
endmodule

// ### verification/sme_assertions.sv
// Checker for the two-wire link joining the host end and the device end.
// Sees only the link signals plus clock and reset; one clock domain.
`timescale 1ns/1ps
module sme_assertions (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link signals
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Open drain: the data outputs only ever carry a low, the enable does the work
	dev_low_only_a: assert property (dev_sda_o == 1'b0)
		else $error("device data output not held low");
	host_low_only_a: assert property (host_sda_o == 1'b0)
		else $error("host data output not held low");
	// Any enabled driver must pull the shared line down
	wire_low_a: assert property (dev_sda_oe || host_sda_oe |-> !sda)
		else $error("data line high while a driver pulls it");
	// Both ends pulling at once while the clock is high would hide a start or stop
	no_fight_a: assert property (scl |-> !(host_sda_oe && dev_sda_oe))
		else $error("both ends drive data with clock high");
	// Device moves its data only in the low phase, after the fall was seen
	dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
		else $error("device data changed outside the clock low phase");
	// A start is the host's alone; the device must be silent
	start_idle_a: assert property (scl && $past(scl) && $fell(sda) |-> !dev_sda_oe)
		else $error("device driving at a start");
	// After a stop the device stays off the line for the next eight cycles
	stop_release_a: assert property (scl && $past(scl) && $rose(sda) |=> !dev_sda_oe [*8])
		else $error("device drives after a stop");
	// Out of reset both ends leave the link idle
	reset_idle_a: assert property ($fell(rst) |-> scl && !host_sda_oe && !dev_sda_oe)
		else $error("link not idle after reset");

	// Main scenarios seen
	start_c: cover property (scl && $past(scl) && $fell(sda));
	ack_c: cover property ($rose(dev_sda_oe));
	stop_c: cover property (scl && $past(scl) && $rose(sda));
endmodule

// ### verification/test_serial_eeprom_memory_map.sv
// Self-checking bench: host end and device end joined by the link interface.
// Assumes the design files and sme_regs.svh are compiled first.
`timescale 1ns/1ps
`include "sme_regs.svh"
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_serial_eeprom_memory_map;
	import sme_pkg::*;
	localparam int           WR     = 400;
	localparam logic [127:0] ID_VAL = 128'h00112233445566778899aabbccddeeff; // Arbitrary value
	// Stimulus and design outputs
	logic         clock;
	logic         rst;
	logic         req;
	logic         req_read;
	logic [3:0]   req_type;
	logic [2:0]   req_sel;
	logic [14:0]  req_addr;
	logic [6:0]   req_len;
	logic [7:0]   wdata;
	logic [2:0]   bus_select_inputs;
	logic         write_guard;
	logic         host_busy, wdata_take, rdata_valid, done, nack_seen, write_busy, sec_locked;
	logic [7:0]   rdata;
	// Bench bookkeeping and reference model
	int           failures, compares, busy_cnt, busy_len;
	logic [31:0]  seed;
	logic [7:0]   main_m [int];
	logic [7:0]   sec_m [64];
	bit           sec_ok [64];
	logic [7:0]   wq [$];
	logic [7:0]   rq [$];

	sme_if u_sme_if ();
	sme_host #(.QUARTER(4)) u_sme_host (.clock(clock), .rst(rst), .req(req), .req_read(req_read),
		.req_type(req_type), .req_sel(req_sel), .req_addr(req_addr), .req_len(req_len), .wdata(wdata),
		.host_busy(host_busy), .wdata_take(wdata_take), .rdata(rdata), .rdata_valid(rdata_valid),
		.done(done), .nack_seen(nack_seen), .link(u_sme_if.host));
	sme_device #(.WR_CYCLES(WR), .FACTORY_ID(ID_VAL)) u_sme_device (.clock(clock), .rst(rst),
		.bus_select_inputs(bus_select_inputs), .write_guard(write_guard), .write_busy(write_busy),
		.sec_locked(sec_locked), .link(u_sme_if.device));
	sme_assertions u_sme_assertions (.clock(clock), .rst(rst), .scl(u_sme_if.scl),
		.host_sda_o(u_sme_if.host_sda_o), .host_sda_oe(u_sme_if.host_sda_oe),
		.dev_sda_o(u_sme_if.dev_sda_o), .dev_sda_oe(u_sme_if.dev_sda_oe), .sda(u_sme_if.sda));

	// 125 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// Length of the latest programming cycle, kept apart from the design's own count
	always @(posedge clock)
	begin
		if (write_busy === 1'b1)
			busy_cnt <= busy_cnt + 1;
		else if (busy_cnt != 0)
		begin
			busy_len <= busy_cnt;
			busy_cnt <= 0;
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Random bytes into the write queue; region 0 main, 1 sector, other values change nothing
	task automatic load(input int n, input logic [14:0] ad, input int rg);
		logic [31:0] r;
		for (int i = 0; i < n; i++)
		begin
			r = rnd();
			wq.push_back(r[7:0]);
			if (rg == 0)
				main_m[{ad[14:6], 6'(ad[5:0] + i)}] = r[7:0];
			if (rg == 1)
			begin
				sec_m[6'(ad[5:0] + i)] = r[7:0];
				sec_ok[6'(ad[5:0] + i)] = 1'b1;
			end
		end
	endtask

	// One whole transfer; bytes to write come from wq, bytes read land in rq
	task automatic xfer(input logic rd, input logic [3:0] ty, input logic [2:0] sl, input logic [14:0] ad,
		input logic [6:0] ln);
		int n;
		int k;
		n = 0;
		k = 0;
		rq.delete();
		@(negedge clock);
		req = 1'b1;
		req_read = rd;
		req_type = ty;
		req_sel = sl;
		req_addr = ad;
		req_len = ln;
		wdata = (wq.size() > 0) ? wq[0] : 8'h00;
		@(negedge clock);
		req = 1'b0;
		`CHK("host busy", 1'b1, host_busy)
		while (done !== 1'b1 && n < 20000)
		begin
			if (wdata_take === 1'b1)
			begin
				k++;
				wdata = (k < wq.size()) ? wq[k] : 8'h00;
			end
			if (rdata_valid === 1'b1)
				rq.push_back(rdata);
			n++;
			@(negedge clock);
		end
		`CHK("frame end", 1'b1, done)
		`CHK("host idle", 1'b0, host_busy)
		wq.delete();
	endtask

	// Wait out programming; a bounded wait, since the cycle is self-timed
	task automatic settle(input logic eb);
		int n;
		n = 0;
		repeat (8) @(negedge clock);
		`CHK("programming started", eb, write_busy)
		while (write_busy === 1'b1 && n < WR + 8)
		begin
			n++;
			@(negedge clock);
		end
		@(negedge clock);
		`CHK("programming ended", 1'b0, write_busy)
		if (eb)
			`CHK("programming length", WR, busy_len)
	endtask

	// Read back and compare every byte the model knows
	task automatic rd_check(input logic [3:0] ty, input logic [14:0] ad, input int ln);
		logic [14:0] p;
		xfer(1'b1, ty, 3'h0, ad, ln[6:0]);
		`CHK("bytes read", ln, rq.size())
		for (int i = 0; i < rq.size(); i++)
		begin
			p = ad + 15'(i);
			if (ty == `SME_TYPE_MAIN && main_m.exists(p))
				`CHK("main byte", main_m[p], rq[i])
			else if (ty != `SME_TYPE_MAIN && ad[10:9] == `SME_SEL_SEC && sec_ok[p[5:0]])
				`CHK("sector byte", sec_m[p[5:0]], rq[i])
			else if (ty != `SME_TYPE_MAIN && ad[10:9] == `SME_SEL_ID)
				`CHK("id byte", ID_VAL[8 * p[3:0] +: 8], rq[i])
		end
	endtask

	task automatic report(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Watchdog: the tests need well under 60000 cycles
	initial
	begin
		#(60000 * 8);
		failures++;
		wrap_up();
	end

	// Main sequence
	initial
	begin
		logic [31:0] r;
		logic [14:0] a;
		logic [14:0] s;
		rst = 1'b1;
		req = 1'b0;
		req_read = 1'b0;
		req_type = `SME_TYPE_MAIN;
		req_sel = 3'h0;
		req_addr = 15'h0000;
		req_len = 7'h01;
		wdata = 8'h00;
		bus_select_inputs = 3'h0;
		write_guard = 1'b0;
		failures = 0;
		compares = 0;
		busy_cnt = 0;
		busy_len = 0;
		seed = 32'h1fcf;
		repeat (16) @(negedge clock);
		rst = 1'b0;
		// Partial page write running off the page end, polled while it programs
		r = rnd();
		a = {r[14:6], 6'h3c};
		load(8, a, 0);
		xfer(1'b0, `SME_TYPE_MAIN, 3'h0, a, 7'd8);
		`CHK("write acked", 1'b0, nack_seen)
		xfer(1'b1, `SME_TYPE_MAIN, 3'h0, a, 7'd1);
		`CHK("busy refuses", 1'b1, nack_seen)
		settle(1'b1);
		rd_check(`SME_TYPE_MAIN, a, 4);
		rd_check(`SME_TYPE_MAIN, {a[14:6], 6'h00}, 4);
		report("main page");
		// Straps and type codes: only a matching address is answered
		bus_select_inputs = 3'h5;
		for (int i = 0; i < 8; i++)
		begin
			xfer(1'b1, `SME_TYPE_MAIN, 3'(i), a, 7'd1);
			`CHK("select match", i == 5, !nack_seen)
		end
		xfer(1'b1, 4'h9, 3'h5, a, 7'd1);
		`CHK("foreign type", 1'b1, nack_seen)
		bus_select_inputs = 3'h0;
		report("select");
		// Guard high: acked, but the array keeps its old byte
		write_guard = 1'b1;
		wq.push_back(~main_m[a]);
		xfer(1'b0, `SME_TYPE_MAIN, 3'h0, a, 7'd1);
		settle(1'b0);
		write_guard = 1'b0;
		rd_check(`SME_TYPE_MAIN, a, 1);
		report("guard");
		// Sector with junk in the ignored bits, then locked and written again
		r = rnd();
		s = {r[14:11], 2'b00, r[8:6], 6'h3a};
		load(8, s, 1);
		xfer(1'b0, `SME_TYPE_EXTRA, 3'h0, s, 7'd8);
		settle(1'b1);
		`CHK("sector open", 1'b0, sec_locked)
		r = rnd();
		rd_check(`SME_TYPE_EXTRA, {r[14:11], 2'b00, r[8:6], 6'h3a}, 8);
		wq.push_back(r[7:0]);
		xfer(1'b0, `SME_TYPE_EXTRA, 3'h0, {r[14:11], 2'b10, r[8:0]}, 7'd1);
		settle(1'b1);
		`CHK("sector locked", 1'b1, sec_locked)
		load(8, s, 2);
		xfer(1'b0, `SME_TYPE_EXTRA, 3'h0, s, 7'd8);
		settle(1'b0);
		rd_check(`SME_TYPE_EXTRA, s, 8);
		report("sector");
		// Identifier: all sixteen bytes from a random start, then an overwrite attempt
		r = rnd();
		s = {r[14:11], 2'b01, r[8:0]};
		rd_check(`SME_TYPE_EXTRA, s, 16);
		load(1, s, 2);
		xfer(1'b0, `SME_TYPE_EXTRA, 3'h0, s, 7'd1);
		settle(1'b0);
		rd_check(`SME_TYPE_EXTRA, s, 16);
		// Extra type with select bits 11 names no region: acked, nothing programmed
		wq.push_back(r[7:0]);
		xfer(1'b0, `SME_TYPE_EXTRA, 3'h0, {r[14:11], 2'b11, r[8:0]}, 7'd1);
		`CHK("unmapped acked", 1'b0, nack_seen)
		settle(1'b0);
		report("identifier");
		wrap_up();
	end
endmodule
